// [verilog/wws_defs.svh]
// Constants for the window supervisor: offsets, reset values and timing.
// How it works
// - Counter decrements every 16384 oscillator cycles.
// - Rollover 40h to 3Fh when active resets.
// - Reload above window limit causes reset.
// - Software mode: off at reset, arm once.
// - Hardware mode: always active, arm ignored.
// - Counter keeps counting while disabled.
// - Arm set with top bit clear forces reset.
// - Active with halt option: halt resets.
// - Six low bits set timeout steps.
// - First step lies between minimum and maximum.
// - Timebase select picks minimum base constant.
// - Control and window registers reset to 7Fh.
// - Arm bit cleared only by reset.
`ifndef WWS_DEFS_SVH
`define WWS_DEFS_SVH

// ****************************************************************
// Register map, byte addresses on the APB side.
// ****************************************************************
`define WWS_OFF_CTRL      12'h000
`define WWS_OFF_WINDOW    12'h004
`define WWS_OFF_CLKCFG    12'h008
`define WWS_OFF_CAUSE     12'h00C

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define WWS_ARM_BIT       7
`define WWS_TOP_BIT       6
`define WWS_CTRL_RST      8'h7F
`define WWS_WIN_RST       7'h7F
`define WWS_CNT_RST       7'h7F
`define WWS_TB_RST        2'h0
`define WWS_CNT_ROLL      7'h40
`define WWS_CAUSE_TOUT    0
`define WWS_CAUSE_WIN     1
`define WWS_CAUSE_FORCE   2
`define WWS_CAUSE_HALT    3
`define WWS_CAUSE_ACTIVE  4

// ****************************************************************
// Timing.
// ****************************************************************
`define WWS_CLK_PERIOD_NS 4
`define WWS_RST_PULSE_NS  30000
`define WWS_PRESCALE_CYC  16384
`define WWS_MIN_BASE_ADD  128
`define WWS_MIN_BASE_MUL  64
`define WWS_TB_LSB0       8'h3B
`define WWS_TB_LSB1       8'h35
`define WWS_TB_LSB2       8'h23
`define WWS_TB_LSB3       8'h36

`endif

// [verilog/wws_pkg.sv]
// Types shared by the window supervisor modules.
package wws_pkg;
  // Reset sequencer states, one-hot.
  typedef enum logic [1:0] {
    WWS_RUN  = 2'b01,
    WWS_HOLD = 2'b10
  } wws_state_t;
endpackage

// [verilog/wws_prescaler.sv]
// Prescaler that paces the supervisor downcounter.
`timescale 1ns/1ps
`include "wws_defs.svh"

module wws_prescaler import wws_pkg::*; #(
  parameter int unsigned PRESCALE = `WWS_PRESCALE_CYC  // Cycles per counter step.
) (
  input  wire logic       clk,     // System clock.
  input  wire logic       rst_n,   // Asynchronous reset, active low.
  input  wire logic [1:0] tb_sel,  // Timebase select.
  input  wire logic       reload,  // Control register written this cycle.
  output logic            tick     // One-cycle step enable.
);
  localparam int unsigned W = $clog2(PRESCALE);

  logic [W-1:0] rem_r;    // Cycles left until the next step.
  logic [W-1:0] rem_nxt;  // Next value of rem_r.
  logic [7:0]   lsb;      // Timebase constant for the minimum base.
  logic [31:0]  min_cyc;  // Least cycles from a write to the first step.
  logic [W-1:0] floor_v;  // Least remaining count after a write.

  // ****************************************************************
  // Minimum base, scaled so a shortened prescaler keeps its shape.
  // ****************************************************************

  // The LSB figure follows the timebase selection.
  always_comb begin
    case (tb_sel)
      2'h0:    lsb = `WWS_TB_LSB0;
      2'h1:    lsb = `WWS_TB_LSB1;
      2'h2:    lsb = `WWS_TB_LSB2;
      default: lsb = `WWS_TB_LSB3;
    endcase
    min_cyc = ((32'(lsb) + `WWS_MIN_BASE_ADD) * `WWS_MIN_BASE_MUL * PRESCALE)
              / `WWS_PRESCALE_CYC;
    floor_v = W'(min_cyc - 32'h1);
  end

  // The step falls when the remaining count runs out.
  assign tick = (rem_r == '0);

  // ****************************************************************
  // Remaining count.
  // ****************************************************************

  // The prescaler is never cleared by a write, since software cannot see
  // its phase; a write only lifts it to the minimum base, so the first
  // step after a write lies between the minimum and the full period.
  always_comb begin
    if (rem_r == '0) begin
      rem_nxt = W'(PRESCALE - 1);
    end else begin
      rem_nxt = rem_r - 1'b1;
    end
    if (reload && (rem_nxt < floor_v)) begin
      rem_nxt = floor_v;
    end
  end

  // Register the remaining count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_r <= W'(PRESCALE - 1);
    end else begin
      rem_r <= rem_nxt;
    end
  end

  // A write never leaves less than the minimum base before a step.
  a_prescale_floor: assert property (@(posedge clk) disable iff (!rst_n)
    reload |=> (rem_r >= $past(floor_v)))
    else $error("Prescaler below minimum base after write.");

endmodule

// [verilog/wws_top.sv]
// Window supervisor with APB registers and reset pulse generation.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "wws_defs.svh"

module wws_top import wws_pkg::*; #(
  parameter int unsigned ADDR_W     = 12,                  // APB address width.
  parameter int unsigned PRESCALE   = `WWS_PRESCALE_CYC,   // Cycles per step.
  parameter int unsigned RST_CYCLES =
    `WWS_RST_PULSE_NS / `WWS_CLK_PERIOD_NS                 // Reset pulse cycles.
) (
  input  wire logic              CLOCK,           // System clock, 250 MHz.
  input  wire logic              RST_N,           // Asynchronous reset, active low.
  input  wire logic              PSEL,            // APB select.
  input  wire logic              PENABLE,         // APB access phase.
  input  wire logic              PWRITE,          // APB direction, high for write.
  input  wire logic [ADDR_W-1:0] PADDR,           // APB byte address.
  input  wire logic [31:0]       PWDATA,          // APB write data.
  input  wire logic [3:0]        PSTRB,           // APB byte strobes.
  output logic      [31:0]       PRDATA,          // APB read data.
  output logic                   PREADY,          // APB ready.
  output logic                   PSLVERR,         // APB error on unmapped address.
  input  wire logic              HW_ACTIVATE_OPT, // Strap: permanent activation.
  input  wire logic              HALT_RESET_OPT,  // Strap: halt causes reset.
  input  wire logic              HALT_REQ,        // Halt instruction, one cycle.
  output logic                   HALT_GRANT,      // Halt may be entered, one cycle.
  output logic                   WDG_RST_N        // Reset pin drive, active low.
);
  localparam int unsigned PW = $clog2(RST_CYCLES);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  wws_state_t  state_r, state_nxt;      // Reset sequencer.
  logic [PW-1:0] pcnt_r, pcnt_nxt;      // Reset pulse length counter.
  logic [6:0]  cnt_r, cnt_nxt;          // Downcounter, delay_step_value.
  logic        arm_r, arm_nxt;          // Software arm bit.
  logic [6:0]  win_r, win_nxt;          // Window limit.
  logic [1:0]  tb_r, tb_nxt;            // Timebase select.
  logic [3:0]  cause_r, cause_nxt;      // Sticky reset causes.
  logic [31:0] prdata_r, prdata_nxt;    // Registered read data.
  logic        grant_r, grant_nxt;      // Registered halt grant.
  logic [1:0]  hw_sync_r, halt_sync_r;  // Strap synchronisers.
  logic [1:0]  cap_cnt_r;               // Strap capture delay.
  logic        hw_opt_r, halt_opt_r;    // Captured straps.
  logic [1:0]  hw_sync_nxt;             // Next value of hw_sync_r.
  logic [1:0]  halt_sync_nxt;           // Next value of halt_sync_r.
  logic [1:0]  cap_cnt_nxt;             // Next value of cap_cnt_r.
  logic        hw_opt_nxt, halt_opt_nxt; // Next captured straps.
  logic        sel_ctrl, sel_win;       // Address decode.
  logic        sel_clk, sel_cause;
  logic        mapped;                  // Address hits a register.
  logic [31:0] rd_data;                 // Read mux output.
  logic        wr_acc;                  // Write access phase.
  logic        ctrl_wr;                 // Control register is written.
  logic        active;                  // Supervisor may reset.
  logic        new_active;              // Active after the present write.
  logic        tick;                    // One step of the downcounter.
  logic        ev_tout, ev_win;         // Reset events.
  logic        ev_force, ev_halt;
  logic        trig;                    // Any reset event.
  logic        holding;                 // Reset pin is being held low.
  logic        done;                    // Last cycle of the reset pulse.

  // ****************************************************************
  // Option straps.
  // ****************************************************************

  // Straps come from outside, so they pass two flops and are caught once,
  // a few edges after release; they never change again until the next RST_N reset.
  always_comb begin
    hw_sync_nxt   = {hw_sync_r[0], HW_ACTIVATE_OPT};
    halt_sync_nxt = {halt_sync_r[0], HALT_RESET_OPT};
    cap_cnt_nxt   = cap_cnt_r;
    hw_opt_nxt    = hw_opt_r;
    halt_opt_nxt  = halt_opt_r;
    if (cap_cnt_r != 2'h3) begin
      cap_cnt_nxt = cap_cnt_r + 2'h1;
    end
    if (cap_cnt_r == 2'h2) begin
      hw_opt_nxt   = hw_sync_r[1];
      halt_opt_nxt = halt_sync_r[1];
    end
  end

  // Register the strap state.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      hw_sync_r   <= 2'h0;
      halt_sync_r <= 2'h0;
      cap_cnt_r   <= 2'h0;
      hw_opt_r    <= 1'b0;
      halt_opt_r  <= 1'b0;
    end else begin
      hw_sync_r   <= hw_sync_nxt;
      halt_sync_r <= halt_sync_nxt;
      cap_cnt_r   <= cap_cnt_nxt;
      hw_opt_r    <= hw_opt_nxt;
      halt_opt_r  <= halt_opt_nxt;
    end
  end

  // ****************************************************************
  // Bus decode.
  // ****************************************************************

  // Address decode; anything else answers with an error.
  always_comb begin
    sel_ctrl  = 1'b0;
    sel_win   = 1'b0;
    sel_clk   = 1'b0;
    sel_cause = 1'b0;
    if (PADDR == ADDR_W'(`WWS_OFF_CTRL)) begin
      sel_ctrl = 1'b1;
    end else if (PADDR == ADDR_W'(`WWS_OFF_WINDOW)) begin
      sel_win = 1'b1;
    end else if (PADDR == ADDR_W'(`WWS_OFF_CLKCFG)) begin
      sel_clk = 1'b1;
    end else if (PADDR == ADDR_W'(`WWS_OFF_CAUSE)) begin
      sel_cause = 1'b1;
    end
    mapped = sel_ctrl | sel_win | sel_clk | sel_cause;
  end

  // Read mux; bits above each register read as zero.
  always_comb begin
    rd_data = 32'h0;
    if (sel_ctrl) begin
      rd_data[7:0] = {arm_r, cnt_r};
    end else if (sel_win) begin
      rd_data[6:0] = win_r;
    end else if (sel_clk) begin
      rd_data[1:0] = tb_r;
    end else if (sel_cause) begin
      rd_data[4:0] = {active, cause_r};
    end
  end

  assign wr_acc = PSEL & PENABLE & PWRITE & mapped;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // ****************************************************************
  // Reset events.
  // ****************************************************************

  assign holding = (state_r == WWS_HOLD);
  assign done = holding && (pcnt_r == PW'(RST_CYCLES - 1));
  assign active = hw_opt_r | arm_r;
  // Control, window and timebase writes are dropped while the reset pin is low; the device is in reset.
  assign ctrl_wr = wr_acc & sel_ctrl & PSTRB[0] & ~holding;
  assign new_active = hw_opt_r | arm_r | PWDATA[`WWS_ARM_BIT];

  // Each event is qualified by the activation it needs.
  always_comb begin
    ev_tout  = tick & active & ~ctrl_wr & ~holding &
               (cnt_r == `WWS_CNT_ROLL);
    ev_win   = ctrl_wr & active & (cnt_r > win_r);
    ev_force = ctrl_wr & new_active & ~PWDATA[`WWS_TOP_BIT];
    ev_halt  = HALT_REQ & active & halt_opt_r & ~holding;
    trig     = ev_tout | ev_win | ev_force | ev_halt;
    grant_nxt = HALT_REQ & ~holding & ~(active & halt_opt_r);
  end

  wws_prescaler #(
    .PRESCALE (PRESCALE)
  ) u_prescaler (
    .clk    (CLOCK),
    .rst_n  (RST_N),
    .tb_sel (tb_r),
    .reload (ctrl_wr),
    .tick   (tick)
  );

  // ****************************************************************
  // Reset sequencer.
  // ****************************************************************

  // The pin is held low for the full pulse; the end of the pulse returns the
  // counter, arm bit, window and timebase to their reset values, as the device reset would.
  always_comb begin
    state_nxt = state_r;
    pcnt_nxt  = pcnt_r;
    case (state_r)
      WWS_RUN: begin
        pcnt_nxt = '0;
        if (trig) begin
          state_nxt = WWS_HOLD;
        end
      end
      WWS_HOLD: begin
        pcnt_nxt = pcnt_r + 1'b1;
        if (done) begin
          state_nxt = WWS_RUN;
          pcnt_nxt  = '0;
        end
      end
      default: begin
        state_nxt = WWS_RUN;
        pcnt_nxt  = '0;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= WWS_RUN;
      pcnt_r  <= '0;
    end else begin
      state_r <= state_nxt;
      pcnt_r  <= pcnt_nxt;
    end
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************

  // Counter, arm bit, window and timebase.
  always_comb begin
    cnt_nxt = cnt_r;
    arm_nxt = arm_r;
    win_nxt = win_r;
    tb_nxt  = tb_r;
    if (done) begin
      cnt_nxt = `WWS_CNT_RST;
      arm_nxt = 1'b0;
      win_nxt = `WWS_WIN_RST;
      tb_nxt  = `WWS_TB_RST;
    end else begin
      if (ctrl_wr) begin
        cnt_nxt = PWDATA[6:0];
        // Arm only ever sets from software.
        if (PWDATA[`WWS_ARM_BIT]) begin
          arm_nxt = 1'b1;
        end
      end else if (tick) begin
        // Free running, even when not active; low bits give the steps.
        cnt_nxt = cnt_r - 7'h01;
      end
      if (wr_acc && sel_win && PSTRB[0] && !holding) begin
        win_nxt = PWDATA[6:0];
      end
      if (wr_acc && sel_clk && PSTRB[0] && !holding) begin
        tb_nxt = PWDATA[1:0];
      end
    end
  end

  // Causes survive the pulse so software can read why it restarted.
  // Write one to clear; a new event in the same cycle wins.
  always_comb begin
    cause_nxt = cause_r;
    if (wr_acc && sel_cause && PSTRB[0]) begin
      cause_nxt = cause_r & ~PWDATA[3:0];
    end
    cause_nxt[`WWS_CAUSE_TOUT]  = cause_nxt[`WWS_CAUSE_TOUT] | ev_tout;
    cause_nxt[`WWS_CAUSE_WIN]   = cause_nxt[`WWS_CAUSE_WIN] | ev_win;
    cause_nxt[`WWS_CAUSE_FORCE] = cause_nxt[`WWS_CAUSE_FORCE] | ev_force;
    cause_nxt[`WWS_CAUSE_HALT]  = cause_nxt[`WWS_CAUSE_HALT] | ev_halt;
    prdata_nxt = prdata_r;
    if (PSEL && !PENABLE && !PWRITE) begin
      prdata_nxt = rd_data;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r    <= `WWS_CNT_RST;
      arm_r    <= 1'b0;
      win_r    <= `WWS_WIN_RST;
      tb_r     <= `WWS_TB_RST;
      cause_r  <= 4'h0;
      prdata_r <= 32'h0;
      grant_r  <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      arm_r    <= arm_nxt;
      win_r    <= win_nxt;
      tb_r     <= tb_nxt;
      cause_r  <= cause_nxt;
      prdata_r <= prdata_nxt;
      grant_r  <= grant_nxt;
    end
  end

  assign PRDATA = prdata_r;
  assign HALT_GRANT = grant_r;
  assign WDG_RST_N = ~holding;

  // ****************************************************************
  // Checks.
  // ****************************************************************

  a_step_decrement: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (tick && !ctrl_wr && !done) |=> (cnt_r == $past(cnt_r) - 7'h01))
    else $error("Counter did not step down on tick.");

  a_timeout_reset: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (tick && active && !holding && !ctrl_wr && cnt_r == 7'h40)
      |=> (!WDG_RST_N && cnt_r == 7'h3F))
    else $error("Rollover did not start a reset.");

  a_window_reset: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (ctrl_wr && active && (cnt_r > win_r)) |=> holding ##1 holding)
    else $error("Early reload did not start a reset.");

  a_arm_sticky: assert property (@(posedge CLOCK) disable iff (!RST_N)
    $fell(arm_r) |-> $past(done))
    else $error("Arm bit cleared without reset.");

  a_hw_active: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (hw_opt_r && ctrl_wr && !PWDATA[6]) |=> !WDG_RST_N)
    else $error("Hardware mode not active.");

  a_force_reset: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (ctrl_wr && PWDATA[7] && !PWDATA[6]) |=> holding && cause_r[2])
    else $error("Forced reset missing.");

  a_halt_reset: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (HALT_REQ && active && halt_opt_r && !holding) |=> (holding && !HALT_GRANT))
    else $error("Halt did not reset.");

  a_pulse_width: assert property (@(posedge CLOCK) disable iff (!RST_N)
    $fell(WDG_RST_N) |-> (!WDG_RST_N)[*8])
    else $error("Reset pulse too short.");

  a_reset_values: assert property (@(posedge CLOCK) disable iff (!RST_N)
    done |=> (cnt_r == 7'h7F && win_r == 7'h7F && !arm_r && WDG_RST_N))
    else $error("Registers not back at reset values.");

endmodule

// [verification/wws_testbench.sv]
// Self-checking testbench for the window supervisor top level.
`timescale 1ns/1ps
`include "wws_defs.svh"

module testbench import wws_pkg::*;;
  // ********************
  // Settings and signals
  // ********************
  localparam int          P      = 64;             // Shortened prescale period.
  localparam int          RC     = 16;             // Shortened reset pulse length.
  localparam logic [11:0] A_CTRL = `WWS_OFF_CTRL;   // Control register.
  localparam logic [11:0] A_WIN  = `WWS_OFF_WINDOW; // Window limit register.
  localparam logic [11:0] A_CLK  = `WWS_OFF_CLKCFG; // Timebase select register.
  localparam logic [11:0] A_CAU  = `WWS_OFF_CAUSE;  // Reset cause register.

  logic        clock      = 1'b0;   // System clock.
  logic        rst_n      = 1'b0;   // Block reset, active low.
  logic        psel       = 1'b0;   // Bus select.
  logic        penable    = 1'b0;   // Bus access phase.
  logic        pwrite     = 1'b0;   // Bus direction.
  logic [11:0] paddr      = 12'h000; // Bus address.
  logic [31:0] pwdata     = 32'h0;  // Bus write data.
  logic [3:0]  pstrb      = 4'hF;   // Bus byte strobes.
  logic [31:0] prdata;              // Bus read data.
  logic        pready;              // Bus ready.
  logic        pslverr;             // Bus error.
  logic        hw_opt     = 1'b0;   // Permanent activation strap.
  logic        halt_opt   = 1'b0;   // Halt causes reset strap.
  logic        halt_req   = 1'b0;   // Halt instruction pulse.
  logic        halt_grant;          // Halt may be entered.
  logic        wdg_rst_n;           // Reset pin drive, active low.
  int          n_fail     = 0;      // Mismatches seen.
  int          tests_run  = 0;      // Comparisons made.

  // 4 ns period.
  initial begin
    forever #2 clock = ~clock;
  end

  // ********************
  // Device under test
  // ********************
  wws_top #(
    .ADDR_W     (12),
    .PRESCALE   (P),
    .RST_CYCLES (RC)
  ) dut (
    .CLOCK           (clock),
    .RST_N           (rst_n),
    .PSEL            (psel),
    .PENABLE         (penable),
    .PWRITE          (pwrite),
    .PADDR           (paddr),
    .PWDATA          (pwdata),
    .PSTRB           (pstrb),
    .PRDATA          (prdata),
    .PREADY          (pready),
    .PSLVERR         (pslverr),
    .HW_ACTIVATE_OPT (hw_opt),
    .HALT_RESET_OPT  (halt_opt),
    .HALT_REQ        (halt_req),
    .HALT_GRANT      (halt_grant),
    .WDG_RST_N       (wdg_rst_n)
  );

  // ********************
  // Shared tasks
  // ********************
  // Ends the run with the verdict.
  task automatic close_out();
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Counts one comparison and reports a difference at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask

  // One bus transfer; an idle edge follows so the strobes never toggle twice in a step.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    pstrb   <= s;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, 4'hF, q, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 8'h00, 4'hF, q, e);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    chk(q, exp);
  endtask

  // Sets the straps, then pulses the block reset for 5 cycles.
  task automatic apply_reset(input logic hw, input logic ho);
    hw_opt   <= hw;
    halt_opt <= ho;
    rst_n    <= 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask

  // Measures the low pulse; pre low cycles were already seen by the caller.
  task automatic pulse_chk(input int pre);
    int n;
    n = pre;
    forever begin
      @(negedge clock);
      if (wdg_rst_n !== 1'b0) break;
      n++;
    end
    chk(32'(n), 32'(RC));
    @(posedge clock);
  endtask

  // Checks the pin after a write; a pulse, if expected, is measured to its end.
  task automatic after_chk(input logic exp, input int pre);
    @(negedge clock);
    chk({31'h0, wdg_rst_n}, {31'h0, exp});
    if (exp) begin
      @(posedge clock);
    end else begin
      pulse_chk(pre);
    end
  endtask

  // Pulses the halt request and checks the grant and the pin.
  task automatic halt_try(input logic exp_rst);
    halt_req <= 1'b1;
    @(posedge clock);
    halt_req <= 1'b0;
    @(negedge clock);
    chk({31'h0, halt_grant}, {31'h0, ~exp_rst});
    after_chk(~exp_rst, 2);
  endtask

  // ********************
  // Scenarios
  // ********************
  // Reset values, a masked write, an unmapped read and the free-running counter.
  task automatic t_free();
    logic [31:0] q0;
    logic [31:0] q1;
    logic        e;
    logic        low;
    low = 1'b0;
    rd(A_CTRL, q0);
    chk({31'h0, q0 == 32'h7F || q0 == 32'h7E}, 32'h1);
    rchk(A_WIN, 32'h7F);
    rchk(A_CLK, 32'h0);
    rchk(A_CAU, 32'h0);
    apb(1'b1, A_WIN, 8'h11, 4'h0, q1, e);
    rchk(A_WIN, 32'h7F);
    apb(1'b0, 12'h010, 8'h00, 4'hF, q1, e);
    chk(q1, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk({31'h0, pready}, 32'h1);
    rd(A_CTRL, q0);
    repeat (2 * P - 3) @(posedge clock);
    rd(A_CTRL, q1);
    chk({25'h0, q0[6:0] - q1[6:0]}, 32'h2);
    // Long enough to pass 40h while still disarmed.
    repeat (66 * P) begin
      @(negedge clock);
      if (wdg_rst_n !== 1'b1) low = 1'b1;
    end
    @(posedge clock);
    chk({31'h0, low}, 32'h0);
    rchk(A_CAU, 32'h0);
  endtask

  // Rollover delay for each timebase, with one to four steps to go.
  task automatic t_timeout();
    int          lsb [4] = '{59, 53, 35, 54};
    int          n;
    logic [31:0] q;
    for (int tb = 0; tb < 4; tb++) begin
      wr(A_CLK, 8'(tb));
      wr(A_CTRL, 8'hC0 | 8'(tb));
      n = 0;
      do begin
        @(negedge clock);
        n++;
      end while (wdg_rst_n !== 1'b0);
      chk({31'h0, n >= (lsb[tb] + 128) * P / 256 + tb * P}, 32'h1);
      chk({31'h0, n <= (tb + 1) * P + 1}, 32'h1);
      pulse_chk(1);
      rd(A_CTRL, q);
      chk({31'h0, q[7]}, 32'h0);
      rchk(A_CAU, 32'h1);
      wr(A_CAU, 8'h01);
    end
  endtask

  // Refreshes twice at the window, then one above it.
  task automatic t_window();
    logic [31:0] q;
    wr(A_WIN, 8'h4F);
    wr(A_CTRL, 8'hCF);
    wr(A_CTRL, 8'h4F);
    after_chk(1'b1, 0);
    rd(A_CTRL, q);
    chk({31'h0, q[7]}, 32'h1);
    wr(A_CTRL, 8'hFF);
    after_chk(1'b1, 0);
    wr(A_CTRL, 8'hFF);
    after_chk(1'b0, 2);
    rchk(A_CAU, 32'h2);
    rchk(A_WIN, 32'h7F);
    wr(A_CAU, 8'h02);
  endtask

  // Top bit cleared without and with the arm bit.
  task automatic t_force();
    wr(A_CTRL, 8'h3F);
    after_chk(1'b1, 0);
    wr(A_CTRL, 8'hBF);
    after_chk(1'b0, 2);
    rchk(A_CAU, 32'h4);
    wr(A_CAU, 8'h04);
  endtask

  // Permanent activation needs no arm bit.
  task automatic t_hw();
    apply_reset(1'b1, 1'b0);
    rchk(A_CAU, 32'h10);
    wr(A_CTRL, 8'h3F);
    after_chk(1'b0, 2);
    rchk(A_CAU, 32'h14);
  endtask

  // Halt with the option off, disarmed, and armed.
  task automatic t_halt();
    apply_reset(1'b0, 1'b0);
    wr(A_CTRL, 8'hFF);
    halt_try(1'b0);
    apply_reset(1'b0, 1'b1);
    halt_try(1'b0);
    wr(A_CTRL, 8'hFF);
    halt_try(1'b1);
    rchk(A_CAU, 32'h8);
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    apply_reset(1'b0, 1'b0);
    t_free();
    t_timeout();
    t_window();
    t_force();
    t_hw();
    t_halt();
    close_out();
  end

  // Cuts a hang short well after the expected run of about 5400 cycles.
  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    close_out();
  end
endmodule
